// ---- verilog/cpu_clock_gen_standby_ctl.sv ----
`timescale 1ns/1ps
module cpu_clock_gen_standby_ctl
#(
    parameter bit LONG_RESET_WAIT = 1'b0
)
(
    // clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_N_I,
    // data memory write and read ports
    input  wire logic        WR_EN_I,
    input  wire logic [11:0] WR_ADDR_I,
    input  wire logic [3:0]  WR_DATA_I,
    input  wire logic        RD_EN_I,
    input  wire logic [11:0] RD_ADDR_I,
    // instruction events
    input  wire logic        STOP_INSTR_I,
    input  wire logic        HALT_INSTR_I,
    input  wire logic        STANDBY_RELEASE_I,
    input  wire logic        RELEASE_BY_INT_I,
    input  wire logic [1:0]  INTERVAL_TIMER_MODE_I,
    // outputs
    output logic [3:0]       RD_DATA_O,
    output logic             CPU_CLK_EN_O,
    output logic             CPU_HOLD_O,
    output logic             OSC_RUN_O,
    output logic             HALTED_O,
    output logic [19:0]      PERIPH_CLK_EN_O
);
    localparam int DW = clkgen_pkg::DIV_WIDTH;

    // ------------------------------------------------------------
    // clock control register
    // ------------------------------------------------------------
    logic [3:0] ctl_q;
    logic [1:0] sel_act_q;
    logic       wr_hit;
    logic       sw_pending_q;
    logic       stop_rel;

    assign wr_hit   = WR_EN_I && (WR_ADDR_I == clkgen_pkg::CPU_CLOCK_CONTROL_ADDR);
    assign stop_rel = STANDBY_RELEASE_I && ctl_q[clkgen_pkg::STOP_POS];

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ctl_q <= clkgen_pkg::CPU_CLOCK_CONTROL_RST;
        else if (STANDBY_RELEASE_I)
            ctl_q <= {2'b00, ctl_q[1:0]};
        else if (STOP_INSTR_I)
            ctl_q[clkgen_pkg::STOP_POS] <= 1'b1;
        else if (HALT_INSTR_I)
            ctl_q[clkgen_pkg::HALT_POS] <= 1'b1;
        else if (wr_hit)
            ctl_q <= WR_DATA_I;
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            RD_DATA_O <= 4'h0;
        else if (RD_EN_I && RD_ADDR_I == clkgen_pkg::CPU_CLOCK_CONTROL_ADDR)
            RD_DATA_O <= ctl_q;
        else
            RD_DATA_O <= 4'h0;
    end

    // ------------------------------------------------------------
    // divider and stabilisation wait
    // ------------------------------------------------------------
    div_bus_if #(.WIDTH(DW)) dbus ();

    div_chain u_div
    (
        .core_clk_i (CORE_CLK_I),
        .rst_n_i    (RST_N_I),
        .bus        (dbus)
    );

    typedef enum logic [1:0]
    {
        ST_RESET_WAIT,
        ST_RUN,
        ST_STOPPED,
        ST_STOP_WAIT
    } state_t;

    state_t     state_q;
    logic [4:0] wait_log2_q;
    logic       wait_done;

    function automatic logic [4:0] mode_wait(input logic [1:0] m);
        case (m)
            2'h0:    mode_wait = 5'(clkgen_pkg::WAIT_MODE0_LOG2);
            2'h1:    mode_wait = 5'(clkgen_pkg::WAIT_MODE1_LOG2);
            2'h2:    mode_wait = 5'(clkgen_pkg::WAIT_MODE2_LOG2);
            default: mode_wait = 5'(clkgen_pkg::WAIT_MODE3_LOG2);
        endcase
    endfunction : mode_wait

    // wait ends when tap n first rises, 2^n periods after the chain was cleared;
    // the top tap has no rise bit, so an all-ones count stands in for it
    assign wait_done = (wait_log2_q == 5'(DW)) ? (&dbus.count)
                                                : dbus.rise[wait_log2_q];
    assign dbus.run  = (state_q != ST_STOPPED);
    assign dbus.clr  = stop_rel;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_q     <= ST_RESET_WAIT;
            wait_log2_q <= 5'h0;
        end
        else
        begin
            case (state_q)
                ST_RESET_WAIT:
                begin
                    wait_log2_q <= LONG_RESET_WAIT ? 5'(clkgen_pkg::RESET_WAIT_LONG_LOG2)
                                                   : 5'(clkgen_pkg::RESET_WAIT_SHORT_LOG2);
                    if (wait_log2_q != 5'h0 && wait_done)
                        state_q <= ST_RUN;
                end
                ST_RUN:
                    if (ctl_q[clkgen_pkg::STOP_POS] && !STANDBY_RELEASE_I)
                        state_q <= ST_STOPPED;
                ST_STOPPED:
                    if (STANDBY_RELEASE_I)
                    begin
                        // release other than by interrupt takes the fixed wait
                        wait_log2_q <= RELEASE_BY_INT_I ? mode_wait(INTERVAL_TIMER_MODE_I)
                                        : 5'(clkgen_pkg::RESET_WAIT_SHORT_LOG2);
                        state_q     <= ST_STOP_WAIT;
                    end
                ST_STOP_WAIT:
                    if (wait_done)
                        state_q <= ST_RUN;
                default:
                    state_q <= ST_RESET_WAIT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // cpu clock enable
    // ------------------------------------------------------------
    // the active selection is only swapped at the end of an old machine cycle,
    // so the switch never exceeds one cycle of the old rate
    logic       tick;

    assign tick = dbus.rise[clkgen_pkg::sel_div_log2(sel_act_q) - 1];

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            sel_act_q    <= 2'h0;
            sw_pending_q <= 1'b0;
        end
        else if (tick && (sw_pending_q || wr_hit))
        begin
            sel_act_q    <= ctl_q[clkgen_pkg::SEL_HI_POS:clkgen_pkg::SEL_LO_POS];
            sw_pending_q <= wr_hit;
        end
        else if (wr_hit)
            sw_pending_q <= 1'b1;
    end
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            CPU_CLK_EN_O <= 1'b0;
            CPU_HOLD_O   <= 1'b1;
            OSC_RUN_O    <= 1'b1;
            HALTED_O     <= 1'b0;
        end
        else
        begin
            // halt and stop both gate the cpu clock; peripherals keep halt clocks
            CPU_CLK_EN_O <= tick && (state_q == ST_RUN) && (ctl_q[3:2] == 2'b00);
            CPU_HOLD_O   <= (state_q != ST_RUN);
            OSC_RUN_O    <= (state_q != ST_STOPPED);
            HALTED_O     <= (ctl_q[3:2] != 2'b00);
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            PERIPH_CLK_EN_O <= '0;
        else
            PERIPH_CLK_EN_O <= dbus.rise;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    reset_clear_a: assert property (@(posedge CORE_CLK_I)
        $rose(RST_N_I) |-> ctl_q == 4'h0) else $error("register not cleared");
    release_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        STANDBY_RELEASE_I |=> ctl_q[3:2] == 2'b00) else $error("mode bits kept");
    stop_set_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        STOP_INSTR_I && !STANDBY_RELEASE_I |=> ctl_q[3]) else $error("stop bit not set");
    halt_set_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        HALT_INSTR_I && !STOP_INSTR_I && !STANDBY_RELEASE_I |=> ctl_q[2])
        else $error("halt bit not set");
    write_load_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        wr_hit && !STOP_INSTR_I && !HALT_INSTR_I && !STANDBY_RELEASE_I
        |=> ctl_q == $past(WR_DATA_I)) else $error("write lost");
    standby_gate_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ctl_q[3:2] != 2'b00 |=> !CPU_CLK_EN_O) else $error("clock in standby");
    switch_time_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        wr_hit && sel_act_q == 2'h0 |-> ##[1:130] sel_act_q == ctl_q[1:0])
        else $error("switch too slow");
    osc_stop_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        state_q == ST_STOPPED |=> !OSC_RUN_O) else $error("oscillator runs in stop");
    reset_wait_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        state_q == ST_RESET_WAIT |-> !CPU_CLK_EN_O) else $error("cpu runs in wait");
endmodule : cpu_clock_gen_standby_ctl

// ---- verilog/clkgen_pkg.sv ----
package clkgen_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] CPU_CLOCK_CONTROL_ADDR = 12'hfb3;
    localparam logic [3:0]  CPU_CLOCK_CONTROL_RST  = 4'h0;
    localparam int          SEL_LO_POS             = 0;
    localparam int          SEL_HI_POS             = 1;
    localparam int          HALT_POS               = 2;
    localparam int          STOP_POS               = 3;
    // ------------------------------------------------------------
    // timing, as log2 of oscillator periods
    // ------------------------------------------------------------
    localparam int          DIV_WIDTH              = 20;
    localparam int          RESET_WAIT_SHORT_LOG2  = 15;
    localparam int          RESET_WAIT_LONG_LOG2   = 17;
    localparam int          WAIT_MODE0_LOG2        = 20;
    localparam int          WAIT_MODE1_LOG2        = 17;
    localparam int          WAIT_MODE2_LOG2        = 15;
    localparam int          WAIT_MODE3_LOG2        = 13;
    // clock period in ns; oscillator taken as the core clock
    localparam int          CORE_CLK_PERIOD_NS     = 10;

    typedef enum logic [1:0]
    {
        MODE_NORMAL,
        MODE_HALT,
        MODE_STOP,
        MODE_PROHIBITED
    } cpu_mode_t;

    function automatic int sel_div_log2(input logic [1:0] sel);
        case (sel)
            2'h0:    sel_div_log2 = 6;
            2'h1:    sel_div_log2 = 4;
            2'h2:    sel_div_log2 = 3;
            default: sel_div_log2 = 2;
        endcase
    endfunction : sel_div_log2
endpackage : clkgen_pkg

// ---- verilog/div_bus_if.sv ----
`timescale 1ns/1ps
interface div_bus_if #(parameter int WIDTH = 20);
    logic             run;
    logic             clr;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] rise;
    modport chain (input run, input clr, output count, output rise);
    modport user  (output run, output clr, input count, input rise);
endinterface : div_bus_if

// ---- verilog/div_chain.sv ----
`timescale 1ns/1ps
module div_chain
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // chain access
    div_bus_if.chain  bus
);
    logic [$bits(bus.count)-1:0] cnt_q;

    // free running binary chain; stands still only while the oscillator is stopped
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (bus.clr)
            cnt_q <= '0;
        else if (bus.run)
            cnt_q <= cnt_q + 1'b1;
    end

    assign bus.count = cnt_q;
    // rise[k] pulses once per 2^(k+1) periods: one-cycle enable per tap
    assign bus.rise  = bus.run ? (~cnt_q & (cnt_q + 1'b1)) : '0;
endmodule : div_chain

// ---- tb/cpu_cycle_model.sv ----
`timescale 1ns/1ps
module cpu_cycle_model
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // machine cycle strobe from the clock generator
    input  wire logic        cycle_en_i,
    // observed spacing and count of machine cycles
    output logic [15:0]      last_gap_o,
    output logic [31:0]      ticks_o
);
    logic [15:0] gap_q;

    // -------------------------------------------------------------
    // core side: one strobe is one machine cycle
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gap_q      <= 16'h0001;
            last_gap_o <= 16'h0000;
            ticks_o    <= 32'h0;
        end
        else if (cycle_en_i)
        begin
            gap_q      <= 16'h0001;
            last_gap_o <= gap_q;
            ticks_o    <= ticks_o + 32'h1;
        end
        // saturate so a long halt cannot wrap into a plausible gap
        else if (gap_q != 16'hffff)
        begin
            gap_q <= gap_q + 16'h0001;
        end
    end
endmodule : cpu_cycle_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [3:0] sel; logic [15:0] gap;} row_t;
    localparam logic [11:0] A = clkgen_pkg::CPU_CLOCK_CONTROL_ADDR;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr_en = 1'b0;
    logic [11:0] wr_addr = 12'h000;
    logic [3:0]  wr_data = 4'h0;
    logic        rd_en = 1'b0;
    logic [11:0] rd_addr = 12'h000;
    logic        stop_p = 1'b0;
    logic        halt_p = 1'b0;
    logic        rel_p = 1'b0;
    logic        by_int = 1'b1;
    logic [1:0]  bt_mode = 2'h3;
    logic [3:0]  rd_data;
    logic        cpu_en, hold, osc_run, halted;
    logic [19:0] periph;
    logic [15:0] gap;
    logic [31:0] ticks;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          t0, cnt, old;
    row_t        rows [4] = '{'{4'h1, 16'h0010}, '{4'h2, 16'h0008},
                              '{4'h3, 16'h0004}, '{4'h0, 16'h0040}};
    int          lim [4] = '{1, 4, 8, 16};

    always #5 clk = ~clk;

    cpu_clock_gen_standby_ctl dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .WR_EN_I(wr_en),
        .WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data), .RD_EN_I(rd_en), .RD_ADDR_I(rd_addr),
        .STOP_INSTR_I(stop_p), .HALT_INSTR_I(halt_p), .STANDBY_RELEASE_I(rel_p),
        .RELEASE_BY_INT_I(by_int), .INTERVAL_TIMER_MODE_I(bt_mode), .RD_DATA_O(rd_data),
        .CPU_CLK_EN_O(cpu_en), .CPU_HOLD_O(hold), .OSC_RUN_O(osc_run),
        .HALTED_O(halted), .PERIPH_CLK_EN_O(periph));
    cpu_cycle_model core (.clk_i(clk), .rst_n_i(rst_n), .cycle_en_i(cpu_en),
        .last_gap_o(gap), .ticks_o(ticks));

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic end_sim;
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        @(posedge clk);
        wr_en   <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en   <= 1'b0;
        wr_addr <= 12'h000;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [3:0] exp);
        @(posedge clk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en   <= 1'b0;
        #1;
        chk("reg", 32'(exp), 32'(rd_data));
    endtask : rd

    // k: 0 stop, 1 halt, 2 release
    task automatic pulse(input int k);
        @(posedge clk);
        {stop_p, halt_p, rel_p} <= 3'b100 >> k;
        @(posedge clk);
        {stop_p, halt_p, rel_p} <= 3'b000;
    endtask : pulse

    task automatic wait_ticks(input int n);
        int s;
        int c;
        s = int'(ticks);
        c = 0;
        while (int'(ticks) < s + n)
        begin
            if (c++ > 80 * n + 100)
            begin
                n_mismatch++;
                end_sim();
            end
            @(posedge clk);
            #1;
        end
    endtask : wait_ticks

    task automatic wait_hold(input int lo, input int hi);
        int c;
        c = 0;
        while (hold === 1'b1 && c <= hi)
        begin
            @(posedge clk);
            #1;
            c++;
        end
        chk("hold_len", 32'h1, 32'(c >= lo && c <= hi));
        if (c > hi)
            end_sim();
    endtask : wait_hold

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        chk("hold_rst", 32'h1, 32'(hold));
        chk("osc_rst", 32'h1, 32'(osc_run));
        @(posedge clk);
        rst_n <= 1'b1;
        wait_hold(32764, 32850);
        wait_ticks(2);
        chk("gap", 32'h40, 32'(gap));
        rd(A, 4'h0);
        old = 0;
        for (int i = 0; i < 4; i++)
        begin
            wr(A, rows[i].sel);
            rd(A, rows[i].sel);
            wait_ticks(lim[old] + 2);
            chk("gap", 32'(rows[i].gap), 32'(gap));
            old = int'(rows[i].sel);
        end
        wr(12'hfb2, 4'h3);
        rd(A, 4'h0);
        wr(A, 4'h3);
        pulse(1);
        rd(A, 4'h7);
        chk("halted", 32'h1, 32'(halted));
        t0 = int'(ticks);
        cnt = 0;
        repeat (64)
        begin
            @(posedge clk);
            #1;
            cnt += int'(periph[2]);
        end
        chk("periph", 32'd8, 32'(cnt));
        chk("frozen", 32'(t0), ticks);
        chk("osc_halt", 32'h1, 32'(osc_run));
        pulse(2);
        rd(A, 4'h3);
        chk("halted", 32'h0, 32'(halted));
        wait_ticks(2);
        chk("gap", 32'h4, 32'(gap));
        pulse(0);
        rd(A, 4'hb);
        chk("osc_stop", 32'h0, 32'(osc_run));
        chk("hold_stop", 32'h1, 32'(hold));
        pulse(2);
        wait_hold(8188, 8270);
        rd(A, 4'h3);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        chk("hold_rst", 32'h1, 32'(hold));
        chk("halted_rst", 32'h0, 32'(halted));
        @(posedge clk);
        rst_n <= 1'b1;
        wait_hold(32764, 32850);
        rd(A, 4'h0);
        end_sim();
    end
endmodule : tb
